//--- core/mgp_pkg.sv
// Constants for the masked general-purpose pin port.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package mgp_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int MGP_MAX_PINS = 8;
    localparam int MGP_AW       = 12;
    localparam int MGP_DW       = 32;

    // ****************************************************************
    // Register map, byte addresses
    // ****************************************************************
    // Data window occupies 12'h000..12'h3FC, mask taken from addr[9:2]
    localparam logic [1:0]  MGP_DATA_WIN  = 2'h0;
    localparam int          MGP_MASK_LSB  = 2;
    localparam logic [11:0] MGP_OFF_DIR   = 12'h400;
    localparam logic [11:0] MGP_OFF_SENSE = 12'h404;
    localparam logic [11:0] MGP_OFF_BOTH  = 12'h408;
    localparam logic [11:0] MGP_OFF_EVENT = 12'h40c;
    localparam logic [11:0] MGP_OFF_IEN   = 12'h410;
    localparam logic [11:0] MGP_OFF_RAW   = 12'h414;
    localparam logic [11:0] MGP_OFF_MSK   = 12'h418;
    localparam logic [11:0] MGP_OFF_ICLR  = 12'h41c;
    localparam logic [11:0] MGP_OFF_FUNC  = 12'h420;
    localparam logic [11:0] MGP_OFF_DRIVE = 12'h424;
    localparam logic [11:0] MGP_OFF_SLEW  = 12'h428;
    localparam logic [11:0] MGP_OFF_PULL  = 12'h42c;
    localparam logic [11:0] MGP_OFF_OD    = 12'h430;
    localparam logic [11:0] MGP_OFF_ADCT  = 12'h434;
    localparam logic [11:0] MGP_OFF_DMAT  = 12'h438;
    localparam logic [11:0] MGP_OFF_LOCK  = 12'h43c;
    localparam logic [11:0] MGP_OFF_CMT   = 12'h440;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0] MGP_DRV_2MA  = 2'h0;
    localparam logic [1:0] MGP_DRV_4MA  = 2'h1;
    localparam logic [1:0] MGP_DRV_8MA  = 2'h2;
    localparam logic [1:0] MGP_DRV_BAD  = 2'h3;
    localparam logic [1:0] MGP_PULL_UP  = 2'h1;
    localparam logic [1:0] MGP_PULL_DN  = 2'h2;
    localparam logic [1:0] MGP_RESP_OK  = 2'h0;
    localparam logic [1:0] MGP_RESP_ERR = 2'h2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  MGP_RST_BYTE = 8'h00;
    localparam logic [15:0] MGP_RST_DRV  = 16'h0000;
    localparam logic [15:0] MGP_RST_PULL = 16'h0000;
    localparam logic [31:0] MGP_RST_WORD = 32'h0000_0000;

endpackage

//--- core/mgp_sync.sv
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is an unrelated level; no word coherence.
module mgp_sync
    import mgp_pkg::*;
#(
    parameter int WIDTH = MGP_MAX_PINS
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } mgp_sync_t;

    mgp_sync_t s_reg;
    mgp_sync_t s_next;

    always_comb begin
        s_next.stage1 = async_in;
        s_next.stage2 = s_reg.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stage2;

endmodule

//--- core/mgp_event.sv
// Event detector for one pin: level or edge, one-cycle hit per edge.
// Assumes a synchronised level; no edge is reported on the first sample.
module mgp_event (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic level,
    input  wire logic sense_level,
    input  wire logic both_edges,
    input  wire logic high_or_rise,
    output logic      hit
);

    typedef struct packed {
        logic prev;
        logic primed;
    } mgp_event_t;

    mgp_event_t s_reg;
    mgp_event_t s_next;
    logic       rise;
    logic       fall;

    always_comb begin
        s_next.prev   = level;
        s_next.primed = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rise = s_reg.primed & level & ~s_reg.prev;
    assign fall = s_reg.primed & ~level & s_reg.prev;

    // Level, both edges, or a single selected edge
    always_comb begin
        if (sense_level) begin
            hit = high_or_rise ? level : ~level;
        end else if (both_edges) begin
            hit = rise | fall;
        end else begin
            hit = high_or_rise ? rise : fall;
        end
    end

endmodule

//--- core/mgp_port.sv
// Masked general-purpose pin port with AXI4-Lite register access.
// Assumes pin levels arrive asynchronously and pads are modelled outside.
//
// Behaviour
// - Up to eight pins, fewer per instance
// - Per-pin direction, inputs after reset
// - Interrupt on level, either edge, both
// - Drive 2/4/8 mA, slew at 8 only
// - Optional pull-up or pull-down, none at reset
// - Optional open-drain, push-pull at reset
// - Plain pin or peripheral, plain at reset
// - No peripheral present means plain pin
// - Mask bit n selects pin n only
// - Masked read returns selected pin levels
// - Masked write updates selected pins together
// - Data mask comes from access address bits
// - Single pin index ranges zero to seven
// - Locked pins refuse pad and event config until unlocked and committed
// - Locked pin set fixed per variant
// - Configuration reads back as stored; unused drive codes are not stored
// - Per-pin enable, clear, raw or masked status
// - Direction in, out or hardware control
// - Pin triggers converter or DMA, still interrupts
module mgp_port
    import mgp_pkg::*;
#(
    parameter int          NUM_PINS       = MGP_MAX_PINS,
    parameter logic [7:0]  PERIPH_PRESENT = 8'hff,
    parameter logic [7:0]  LOCKED_PINS    = 8'h00,
    // Arbitrary unlock key value
    parameter logic [31:0] UNLOCK_KEY     = 32'h5a5a_c3c3
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe,
    output logic [7:0]       periph_in,
    input  wire logic [7:0]  periph_out,
    input  wire logic [7:0]  periph_oe,
    output logic [15:0]      drive_sel,
    output logic [7:0]       slew_limit,
    output logic [7:0]       pull_up,
    output logic [7:0]       pull_down,
    output logic [7:0]       int_status,
    output logic [7:0]       adc_trigger,
    output logic [7:0]       dma_trigger
);

    // ****************************************************************
    // State
    // ****************************************************************
    // Pins beyond NUM_PINS are absent
    localparam logic [7:0] PIN_MASK = 8'((1 << NUM_PINS) - 1);

    typedef struct packed {
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  dout;
        logic [7:0]  dir;
        logic [7:0]  func;
        logic [7:0]  sense;
        logic [7:0]  both;
        logic [7:0]  ev;
        logic [7:0]  ien;
        logic [7:0]  raw;
        logic [15:0] drive;
        logic [7:0]  slew;
        logic [15:0] pull;
        logic [7:0]  od;
        logic [7:0]  adc_en;
        logic [7:0]  dma_en;
        logic        unlocked;
        logic [7:0]  commit;
    } mgp_state_t;

    mgp_state_t s_reg;
    mgp_state_t s_next;

    logic [7:0] level;
    logic [7:0] hit;
    logic [7:0] hw_ctl;
    logic [7:0] cfg_ok;

    function automatic logic [15:0] expand2(input logic [7:0] m);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < MGP_MAX_PINS; i++) begin
            r[2*i +: 2] = {2{m[i]}};
        end
        return r;
    endfunction

    // ****************************************************************
    // Pin sampling and event detection
    // ****************************************************************
    mgp_sync #(
        .WIDTH (MGP_MAX_PINS)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (level)
    );

    for (genvar g = 0; g < MGP_MAX_PINS; g++) begin : g_pin
        logic pin_hit;
        mgp_event u_event (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .level        (level[g]),
            .sense_level  (s_reg.sense[g]),
            .both_edges   (s_reg.both[g]),
            .high_or_rise (s_reg.ev[g]),
            .hit          (pin_hit)
        );
        assign hit[g] = pin_hit & PIN_MASK[g];
    end

    // ****************************************************************
    // Register access
    // ****************************************************************
    // Unlocked pins, or protected pins with their commit bit set
    assign cfg_ok = PIN_MASK & (~LOCKED_PINS | s_reg.commit);

    always_comb begin
        logic [7:0]  wen8;
        logic [15:0] wen16;
        logic [7:0]  dmask;
        logic [7:0]  wd8;
        logic [15:0] wd16;
        logic [15:0] drv_new;
        logic [7:0]  clr;
        logic [31:0] rd;
        logic        rd_ok;
        logic        wr_ok;
        wen8    = '0;
        wen16   = '0;
        dmask   = '0;
        wd8     = '0;
        wd16    = '0;
        drv_new = '0;
        clr     = '0;
        rd      = MGP_RST_WORD;
        rd_ok   = 1'b1;
        wr_ok   = 1'b1;
        s_next  = s_reg;

        if (s_axi_awvalid && !s_reg.aw_held) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_held) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Write performed once address and data are both held
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            wd8   = s_reg.w_data[7:0];
            wd16  = s_reg.w_data[15:0];
            wen8  = cfg_ok & {8{s_reg.w_strb[0]}};
            wen16 = expand2(cfg_ok) & {{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            if (s_reg.aw_addr[11:10] == MGP_DATA_WIN) begin
                // Mask from address bits, all selected pins at once
                dmask = s_reg.aw_addr[MGP_MASK_LSB +: 8] & PIN_MASK;
                dmask = dmask & {8{s_reg.w_strb[0]}};
                s_next.dout = (s_reg.dout & ~dmask) | (wd8 & dmask);
            end else begin
                unique case (s_reg.aw_addr)
                    MGP_OFF_DIR: s_next.dir = (s_reg.dir & ~wen8) | (wd8 & wen8);
                    MGP_OFF_SENSE: s_next.sense = (s_reg.sense & ~wen8) | (wd8 & wen8);
                    MGP_OFF_BOTH: s_next.both = (s_reg.both & ~wen8) | (wd8 & wen8);
                    MGP_OFF_EVENT: s_next.ev = (s_reg.ev & ~wen8) | (wd8 & wen8);
                    MGP_OFF_IEN: begin
                        wen8 = PIN_MASK & {8{s_reg.w_strb[0]}};
                        s_next.ien = (s_reg.ien & ~wen8) | (wd8 & wen8);
                    end
                    MGP_OFF_ICLR: clr = wd8 & PIN_MASK & {8{s_reg.w_strb[0]}};
                    MGP_OFF_FUNC: s_next.func = (s_reg.func & ~wen8) | (wd8 & wen8);
                    MGP_OFF_DRIVE: begin
                        drv_new = (s_reg.drive & ~wen16) | (wd16 & wen16);
                        // Unused drive code leaves that pin unchanged
                        for (int i = 0; i < MGP_MAX_PINS; i++) begin
                            if (drv_new[2*i +: 2] != MGP_DRV_BAD) begin
                                s_next.drive[2*i +: 2] = drv_new[2*i +: 2];
                            end
                        end
                    end
                    MGP_OFF_SLEW: s_next.slew = (s_reg.slew & ~wen8) | (wd8 & wen8);
                    MGP_OFF_PULL: s_next.pull = (s_reg.pull & ~wen16) | (wd16 & wen16);
                    MGP_OFF_OD: s_next.od = (s_reg.od & ~wen8) | (wd8 & wen8);
                    MGP_OFF_ADCT: begin
                        wen8 = PIN_MASK & {8{s_reg.w_strb[0]}};
                        s_next.adc_en = (s_reg.adc_en & ~wen8) | (wd8 & wen8);
                    end
                    MGP_OFF_DMAT: begin
                        wen8 = PIN_MASK & {8{s_reg.w_strb[0]}};
                        s_next.dma_en = (s_reg.dma_en & ~wen8) | (wd8 & wen8);
                    end
                    MGP_OFF_LOCK: s_next.unlocked = (s_reg.w_data == UNLOCK_KEY);
                    MGP_OFF_CMT: begin
                        if (s_reg.unlocked && s_reg.w_strb[0]) begin
                            s_next.commit = wd8 & LOCKED_PINS;
                        end
                    end
                    MGP_OFF_RAW, MGP_OFF_MSK: wr_ok = 1'b1;
                    default: wr_ok = 1'b0;
                endcase
            end
            s_next.bresp = wr_ok ? MGP_RESP_OK : MGP_RESP_ERR;
        end

        // Sticky status, a new event wins over a clear
        s_next.raw = (s_reg.raw & ~clr) | hit;

        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.rvalid) begin
            if (s_axi_araddr[11:10] == MGP_DATA_WIN) begin
                dmask = s_axi_araddr[MGP_MASK_LSB +: 8] & PIN_MASK;
                rd    = {24'h00_0000, level & dmask};
            end else begin
                unique case (s_axi_araddr)
                    MGP_OFF_DIR:   rd = {24'h00_0000, s_reg.dir};
                    MGP_OFF_SENSE: rd = {24'h00_0000, s_reg.sense};
                    MGP_OFF_BOTH:  rd = {24'h00_0000, s_reg.both};
                    MGP_OFF_EVENT: rd = {24'h00_0000, s_reg.ev};
                    MGP_OFF_IEN:   rd = {24'h00_0000, s_reg.ien};
                    MGP_OFF_RAW:   rd = {24'h00_0000, s_reg.raw};
                    MGP_OFF_MSK:   rd = {24'h00_0000, s_reg.raw & s_reg.ien};
                    MGP_OFF_ICLR:  rd = MGP_RST_WORD;
                    MGP_OFF_FUNC:  rd = {24'h00_0000, s_reg.func};
                    MGP_OFF_DRIVE: rd = {16'h0000, s_reg.drive};
                    MGP_OFF_SLEW:  rd = {24'h00_0000, s_reg.slew};
                    MGP_OFF_PULL:  rd = {16'h0000, s_reg.pull};
                    MGP_OFF_OD:    rd = {24'h00_0000, s_reg.od};
                    MGP_OFF_ADCT:  rd = {24'h00_0000, s_reg.adc_en};
                    MGP_OFF_DMAT:  rd = {24'h00_0000, s_reg.dma_en};
                    MGP_OFF_LOCK:  rd = {31'h0000_0000, ~s_reg.unlocked};
                    MGP_OFF_CMT:   rd = {24'h00_0000, s_reg.commit};
                    default:       rd_ok = 1'b0;
                endcase
            end
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd;
            s_next.rresp  = rd_ok ? MGP_RESP_OK : MGP_RESP_ERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg          <= '0;
            s_reg.dout     <= MGP_RST_BYTE;
            s_reg.dir      <= MGP_RST_BYTE;
            s_reg.func     <= MGP_RST_BYTE;
            s_reg.drive    <= MGP_RST_DRV;
            s_reg.pull     <= MGP_RST_PULL;
            s_reg.od       <= MGP_RST_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Pins and pads
    // ****************************************************************
    // Function select only takes effect where a peripheral exists
    assign hw_ctl = s_reg.func & PERIPH_PRESENT & PIN_MASK;

    for (genvar g = 0; g < MGP_MAX_PINS; g++) begin : g_pad
        logic drv_val;
        logic drv_en;
        assign drv_val = hw_ctl[g] ? periph_out[g] : s_reg.dout[g];
        assign drv_en  = PIN_MASK[g] & (hw_ctl[g] ? periph_oe[g] : s_reg.dir[g]);
        assign pin_out[g] = drv_val;
        // Open drain drives low only
        assign pin_oe[g] = drv_en & (~s_reg.od[g] | ~drv_val);
        assign slew_limit[g] = s_reg.slew[g] & (s_reg.drive[2*g +: 2] == MGP_DRV_8MA);
        assign pull_up[g]   = PIN_MASK[g] & (s_reg.pull[2*g +: 2] == MGP_PULL_UP);
        assign pull_down[g] = PIN_MASK[g] & (s_reg.pull[2*g +: 2] == MGP_PULL_DN);
    end

    assign periph_in   = level & hw_ctl;
    assign drive_sel   = s_reg.drive;
    assign int_status  = s_reg.raw & s_reg.ien;
    assign adc_trigger = hit & s_reg.adc_en;
    assign dma_trigger = hit & s_reg.dma_en;

    assign s_axi_awready = ~s_reg.aw_held;
    assign s_axi_wready  = ~s_reg.w_held;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = ~s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;

endmodule

//--- sim/mgp_port_monitor.sv
// Bus and pad checker for the masked pin port.
// Assumes one clock domain and a bind onto mgp_port.
module mgp_port_monitor
    import mgp_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  pin_oe,
    input wire logic [15:0] drive_sel,
    input wire logic [7:0]  slew_limit,
    input wire logic [7:0]  pull_up,
    input wire logic [7:0]  pull_down,
    input wire logic [7:0]  int_status
);
    timeunit 1ns / 1ps;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    property p_wr_resp; s_wr_take |-> ##2 s_axi_bvalid; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_slew; slew_limit[0] |-> drive_sel[1:0] == MGP_DRV_8MA; endproperty
    property p_pull; (pull_up & pull_down) == 8'h00; endproperty
    property p_rst; $rose(aresetn) |-> pin_oe == 8'h00 && pull_up == 8'h00
        && drive_sel == 16'h0000 && int_status == 8'h00; endproperty
    property p_sticky; int_status[0] |=> int_status[0] || $rose(s_axi_bvalid); endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
    a_b_hold: assert property (p_b_hold) else $error("response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
    a_slew: assert property (p_slew) else $error("slew below 8 mA");
    a_pull: assert property (p_pull) else $error("both pulls on");
    a_rst: assert property (p_rst) else $error("bad reset state");
    a_sticky: assert property (p_sticky) else $error("status lost");
endmodule

//--- sim/mgp_pad_model.sv
// Pads and outside world of the pin port.
// Assumes undriven pins without pull wander every cycle.
module mgp_pad_model (
    input wire logic       aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] pull_down,
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_en,
    output logic     [7:0] pin_in
);
    timeunit 1ns / 1ps;
    logic [7:0] float_reg = 8'h55;
    always_ff @(posedge aclk) float_reg <= ~float_reg;
    // Pin n of every vector is the same wire
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_level[i] :
                pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : float_reg[i];
        end
    end
endmodule

//--- sim/mgp_port_test.sv
// Self-checking bench for the masked pin port.
// Assumes the pad model and the checker in this folder.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module mgp_port_test
    import mgp_pkg::*;
;
    timeunit 1ns / 1ps;
    localparam logic [31:0] KEY = 32'h1234_abcd;
    localparam logic [11:0] CFG [8] = '{MGP_OFF_DIR, MGP_OFF_SENSE, MGP_OFF_BOTH,
        MGP_OFF_EVENT, MGP_OFF_IEN, MGP_OFF_FUNC, MGP_OFF_OD, MGP_OFF_SLEW};
    localparam logic [4:0] MODES [5] = '{5'h15, 5'h12, 5'h05, 5'h02, 5'h09};
    logic aclk, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, adc_seen = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  pin_in, pin_out, pin_oe, periph_in, periph_out = 0, periph_oe = 0;
    logic [7:0]  slew_limit, pull_up, pull_down, int_status, adc_trigger, dma_trigger;
    logic [7:0]  ext_level = 0, ext_en = 0, dout = 0, m, v, md, lfsr = 8'h4e;
    logic [15:0] drive_sel;
    int          err_count = 0, checks = 0;
    mgp_port #(.LOCKED_PINS(8'h80), .UNLOCK_KEY(KEY)) dut (.*);
    mgp_pad_model u_pad (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up(pull_up), .pull_down(pull_down), .ext_level(ext_level),
        .ext_en(ext_en), .pin_in(pin_in));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] nx(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] mwr(input logic [7:0] o, k, d);
        return (o & ~k) | (d & k);
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        `CHK(r, MGP_RESP_OK)
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK(d, e)
        `CHK(r, MGP_RESP_OK)
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************************************
    // Clock, reset, watchdog and tests
    // ****************************************************************
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) if (adc_trigger[0] && dma_trigger[0]) adc_seen <= 1'b1;
    initial begin
        #40us;
        err_count++;
        complete_run;
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(CFG[i], 0);
        rchk(MGP_OFF_DRIVE, 0);
        rchk(MGP_OFF_PULL, 0);
        done("reset");
        for (int i = 0; i < 8; i++) begin
            lfsr = nx(lfsr);
            w(CFG[i], {24'h0, lfsr});
            rchk(CFG[i], {24'h0, i == 4 ? lfsr : lfsr & 8'h7f});
        end
        w(MGP_OFF_LOCK, KEY);
        w(MGP_OFF_CMT, 32'h80);
        for (int i = 0; i < 8; i++) begin
            lfsr = nx(lfsr);
            w(CFG[i], {24'h0, lfsr});
            rchk(CFG[i], {24'h0, lfsr});
            w(CFG[i], 0);
        end
        done("lock");
        rd(12'h800, d, r);
        `CHK({r, d}, {MGP_RESP_ERR, 32'h0})
        wr(12'h800, 32'h1, r);
        `CHK(r, MGP_RESP_ERR)
        done("unmapped");
        w(MGP_OFF_DRIVE, 32'he4);
        `CHK(drive_sel, 16'h0024)
        w(MGP_OFF_SLEW, 32'hff);
        `CHK(slew_limit, 8'h04)
        w(MGP_OFF_PULL, 32'h9);
        `CHK({pull_up, pull_down}, 16'h0102)
        w(MGP_OFF_FUNC, 32'h1);
        periph_out <= 8'h01;
        periph_oe <= 8'h01;
        repeat (3) @(posedge aclk);
        `CHK({pin_out[0], pin_oe[0], periph_in}, 10'h301)
        w(MGP_OFF_FUNC, 0);
        done("pad");
        w(MGP_OFF_DIR, 32'hff);
        w(12'h3fc, 0);
        for (int i = 0; i < 12; i++) begin
            lfsr = nx(lfsr);
            m = i == 0 ? 8'h00 : i == 1 ? 8'hff : lfsr;
            lfsr = nx(lfsr);
            v = lfsr;
            w({2'b00, m, 2'b00}, {24'h0, v});
            dout = mwr(dout, m, v);
            `CHK(pin_out, dout)
            lfsr = nx(lfsr);
            rchk({2'b00, lfsr, 2'b00}, {24'h0, dout & lfsr});
        end
        `CHK(pin_oe, 8'hff)
        w(MGP_OFF_OD, 32'hff);
        `CHK(pin_oe, ~dout)
        w(MGP_OFF_OD, 0);
        done("data");
        w(MGP_OFF_DIR, 0);
        ext_en <= 8'hff;
        w(MGP_OFF_IEN, 32'h0f);
        w(MGP_OFF_ADCT, 32'hff);
        w(MGP_OFF_DMAT, 32'h01);
        for (int i = 0; i < 5; i++) begin
            md = {3'b000, MODES[i]};
            w(MGP_OFF_SENSE, {24'h0, {8{md[4]}}});
            w(MGP_OFF_BOTH, {24'h0, {8{md[3]}}});
            w(MGP_OFF_EVENT, {24'h0, {8{md[2]}}});
            ext_level <= {8{md[1]}};
            repeat (4) @(posedge aclk);
            w(MGP_OFF_ICLR, 32'hff);
            rchk(MGP_OFF_RAW, 0);
            ext_level <= {8{md[0]}};
            repeat (4) @(posedge aclk);
            rchk(MGP_OFF_RAW, 32'hff);
            rchk(MGP_OFF_MSK, 32'h0f);
            `CHK(int_status, 8'h0f)
            w(MGP_OFF_ICLR, 32'hff);
            rchk(MGP_OFF_RAW, md[4] ? 32'hff : 32'h0);
        end
        `CHK(adc_seen, 1'b1)
        done("interrupt");
        complete_run;
    end
endmodule
bind mgp_port mgp_port_monitor u_mon (.*);
